// [src/i2csa_slave.v]
// Two-wire bus slave with strap-selected address and register store
`timescale 1ns/1ns
`default_nettype none
`include "i2csa_map.vh"

module i2csa_slave (
  input  wire                     clk_sys,
  input  wire                     rst_n,
  input  wire                     scl_in,
  input  wire                     sda_in,
  output wire                     sda_out,
  output wire                     sda_oe,
  input  wire                     addr_strap_high,
  input  wire                     addr_strap_low,
  input  wire                     rx_ready,
  output reg                      wr_valid_q,
  output reg  [`I2CSA_REG_AW-1:0] wr_addr_q,
  output reg  [7:0]               wr_data_q,
  output reg                      bus_busy_q,
  output reg                      addressed_q,
  output reg                      dir_read_q
);

  localparam [4:0] S_IDLE  = 5'h01;
  localparam [4:0] S_RX    = 5'h02;
  localparam [4:0] S_ACK   = 5'h04;
  localparam [4:0] S_TX    = 5'h08;
  localparam [4:0] S_TXACK = 5'h10;

  // Strap code from what the pin was seen to do during the address byte
  function [1:0] strap_code;
    input seen_low;
    input seen_high;
    input diff_scl;
    begin
      if (!seen_low) begin
        strap_code = `I2CSA_STRAP_SUPPLY;
      end else if (!seen_high) begin
        strap_code = `I2CSA_STRAP_GROUND;
      end else if (!diff_scl) begin
        strap_code = `I2CSA_STRAP_CLOCK;
      end else begin
        strap_code = `I2CSA_STRAP_DATA;
      end
    end
  endfunction

  wire [3:0] clean;
  reg        scl_q;
  reg        sda_q;

  i2csa_sync u_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .async_in ({addr_strap_low, addr_strap_high, sda_in, scl_in}),
    .clean_q  (clean)
  );

  wire scl_now  = clean[0];
  wire sda_now  = clean[1];
  wire strap_h  = clean[2];
  wire strap_l  = clean[3];

  wire scl_rise = scl_now & ~scl_q;
  wire scl_fall = ~scl_now & scl_q;
  wire start_ev = scl_now & scl_q & sda_q & ~sda_now;
  wire stop_ev  = scl_now & scl_q & ~sda_q & sda_now;

  reg [4:0]               state_q;
  reg [1:0]               kind_q;
  reg [3:0]               cnt_q;
  reg [7:0]               shift_q;
  reg                     oe_q;
  reg                     ack_q;
  reg                     tx_go_q;
  reg [`I2CSA_REG_AW-1:0] sel_q;
  reg [1:0]               h_flags_q;
  reg [1:0]               l_flags_q;
  reg                     h_dscl_q;
  reg                     l_dscl_q;
  wire [7:0]              rd_data;

  i2csa_regfile u_regs (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .wr_en     (wr_valid_q),
    .wr_addr   (wr_addr_q),
    .wr_data   (wr_data_q),
    .rd_addr   (sel_q),
    .rd_data_q (rd_data)
  );

  wire [1:0] code_h   = strap_code(h_flags_q[0], h_flags_q[1], h_dscl_q);
  wire [1:0] code_l   = strap_code(l_flags_q[0], l_flags_q[1], l_dscl_q);
  wire [7:0] own_addr = `I2CSA_ADDR_BASE + {3'h0, code_h, code_l, 1'b0};
  wire       addr_hit = (shift_q[7:1] == own_addr[7:1]);

  // Limitation: the pull changes about five cycles after the pin clock falls,
  // so the master must keep the clock low for at least six system cycles
  // slave only pulls low, never makes conditions
  assign sda_out = 1'b0;
  assign sda_oe  = oe_q;

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_now;
      sda_q <= sda_now;
    end
  end

  // watch straps between START and the address decision
  always @(posedge clk_sys) begin
    if (!rst_n || start_ev) begin
      h_flags_q <= 2'h0;
      l_flags_q <= 2'h0;
      h_dscl_q  <= 1'b0;
      l_dscl_q  <= 1'b0;
    end else if (state_q == S_RX && kind_q == `I2CSA_KIND_ADDR) begin
      h_flags_q <= h_flags_q | {strap_h, ~strap_h};
      l_flags_q <= l_flags_q | {strap_l, ~strap_l};
      h_dscl_q  <= h_dscl_q | (strap_h ^ scl_now);
      l_dscl_q  <= l_dscl_q | (strap_l ^ scl_now);
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q     <= S_IDLE;
      kind_q      <= `I2CSA_KIND_ADDR;
      cnt_q       <= `I2CSA_CNT_ZERO;
      shift_q     <= `I2CSA_BYTE_RST;
      oe_q        <= 1'b0;
      ack_q       <= 1'b0;
      tx_go_q     <= 1'b0;
      sel_q       <= `I2CSA_SEL_RST;
      wr_valid_q  <= 1'b0;
      wr_addr_q   <= `I2CSA_SEL_RST;
      wr_data_q   <= `I2CSA_BYTE_RST;
      bus_busy_q  <= 1'b0;
      addressed_q <= 1'b0;
      dir_read_q  <= 1'b0;
    end else begin
      wr_valid_q <= 1'b0;
      if (start_ev) begin
        bus_busy_q  <= 1'b1;
        state_q     <= S_RX;
        kind_q      <= `I2CSA_KIND_ADDR;
        cnt_q       <= `I2CSA_CNT_ZERO;
        oe_q        <= 1'b0;
        addressed_q <= 1'b0;
      end else if (stop_ev) begin
        bus_busy_q  <= 1'b0;
        state_q     <= S_IDLE;
        oe_q        <= 1'b0;
        addressed_q <= 1'b0;
      end else begin
        case (state_q)
          S_IDLE: begin
            oe_q <= 1'b0;
          end
          S_RX: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_now};
              cnt_q   <= cnt_q + `I2CSA_CNT_ONE;
            end else if (scl_fall && cnt_q == `I2CSA_BITS_PER_BYTE) begin
              cnt_q <= `I2CSA_CNT_ZERO;
              if (kind_q == `I2CSA_KIND_ADDR) begin
                if (addr_hit) begin
                  addressed_q <= 1'b1;
                  dir_read_q  <= shift_q[0];
                  tx_go_q     <= shift_q[0];
                  kind_q      <= `I2CSA_KIND_SEL;
                  ack_q       <= 1'b1;
                  oe_q        <= 1'b1;
                  state_q     <= S_ACK;
                end else begin
                  state_q <= S_IDLE;
                end
              end else if (kind_q == `I2CSA_KIND_SEL) begin
                // register select, channel must be zero
                sel_q   <= shift_q[`I2CSA_SEL_HI:`I2CSA_SEL_LO];
                ack_q   <= (shift_q[`I2CSA_CH_HI:`I2CSA_CH_LO] == `I2CSA_CH_OK);
                oe_q    <= (shift_q[`I2CSA_CH_HI:`I2CSA_CH_LO] == `I2CSA_CH_OK);
                kind_q  <= `I2CSA_KIND_DATA;
                state_q <= S_ACK;
              end else begin
                ack_q   <= rx_ready;
                oe_q    <= rx_ready;
                state_q <= S_ACK;
                if (rx_ready) begin
                  wr_valid_q <= 1'b1;
                  wr_addr_q  <= sel_q;
                  wr_data_q  <= shift_q;
                end
              end
            end
          end
          S_ACK: begin
            // hold low for the whole slot; on its falling edge release, or drive the first read bit
            if (scl_fall) begin
              if (!ack_q) begin
                oe_q    <= 1'b0;
                state_q <= S_IDLE;
              end else if (tx_go_q) begin
                // First read bit goes out right after the address ack
                shift_q <= {rd_data[6:0], 1'b0};
                oe_q    <= ~rd_data[7];
                cnt_q   <= `I2CSA_CNT_ONE;
                state_q <= S_TX;
              end else begin
                oe_q    <= 1'b0;
                state_q <= S_RX;
              end
            end
          end
          S_TX: begin
            // change data only while clock low
            if (scl_fall) begin
              if (cnt_q == `I2CSA_BITS_PER_BYTE) begin
                oe_q    <= 1'b0;
                state_q <= S_TXACK;
              end else begin
                oe_q    <= ~shift_q[7];
                shift_q <= {shift_q[6:0], 1'b0};
                cnt_q   <= cnt_q + `I2CSA_CNT_ONE;
              end
            end
          end
          S_TXACK: begin
            // master ack sampled on rising clock
            if (scl_rise) begin
              ack_q <= ~sda_now;
            end else if (scl_fall) begin
              if (ack_q) begin
                shift_q <= {rd_data[6:0], 1'b0};
                oe_q    <= ~rd_data[7];
                cnt_q   <= `I2CSA_CNT_ONE;
                state_q <= S_TX;
              end else begin
                oe_q    <= 1'b0;
                state_q <= S_IDLE;
              end
            end
          end
          default: begin
            state_q <= S_IDLE;
            oe_q    <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // i2csa_slave
`default_nettype wire

// [src/i2csa_map.vh]
// Constants for the strap-addressed two-wire slave
`ifndef I2CSA_MAP_VH
`define I2CSA_MAP_VH

// Address byte base and strap codes
`define I2CSA_ADDR_BASE     8'h90
`define I2CSA_STRAP_SUPPLY  2'h0
`define I2CSA_STRAP_GROUND  2'h1
`define I2CSA_STRAP_CLOCK   2'h2
`define I2CSA_STRAP_DATA    2'h3

// Byte framing
`define I2CSA_BITS_PER_BYTE 4'h8
`define I2CSA_CNT_ZERO      4'h0
`define I2CSA_CNT_ONE       4'h1

// Register-select byte fields
`define I2CSA_SEL_HI        6
`define I2CSA_SEL_LO        3
`define I2CSA_CH_HI         2
`define I2CSA_CH_LO         1
`define I2CSA_CH_OK         2'h0

// Byte kinds inside an access
`define I2CSA_KIND_ADDR     2'h0
`define I2CSA_KIND_SEL      2'h1
`define I2CSA_KIND_DATA     2'h2

// Widths and resets
`define I2CSA_REG_AW        4
`define I2CSA_REG_WORDS     16
`define I2CSA_BYTE_RST      8'h00
`define I2CSA_SEL_RST       4'h0
`define I2CSA_SYNC_RST      4'hf

`endif

// [src/i2csa_sync.v]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
`include "i2csa_map.vh"

module i2csa_sync (
  input  wire       clk_sys,
  input  wire       rst_n,
  input  wire [3:0] async_in,
  output reg  [3:0] clean_q
);

  reg [3:0] meta_q;
  reg [3:0] s2_q;
  reg [3:0] s3_q;

  // Lines idle high through pull-ups, so reset to ones
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      meta_q  <= `I2CSA_SYNC_RST;
      s2_q    <= `I2CSA_SYNC_RST;
      s3_q    <= `I2CSA_SYNC_RST;
      clean_q <= `I2CSA_SYNC_RST;
    end else begin
      meta_q  <= async_in;
      s2_q    <= meta_q;
      s3_q    <= s2_q;
      // A change counts only once stages two and three agree
      clean_q <= ((s2_q ~^ s3_q) & s2_q) | ((s2_q ^ s3_q) & clean_q);
    end
  end

endmodule // i2csa_sync
`default_nettype wire

// [src/i2csa_regfile.v]
// Sixteen-byte register store with registered read data
`timescale 1ns/1ns
`default_nettype none
`include "i2csa_map.vh"

module i2csa_regfile (
  input  wire                     clk_sys,
  input  wire                     rst_n,
  input  wire                     wr_en,
  input  wire [`I2CSA_REG_AW-1:0] wr_addr,
  input  wire [7:0]               wr_data,
  input  wire [`I2CSA_REG_AW-1:0] rd_addr,
  output reg  [7:0]               rd_data_q
);

  reg [7:0] mem [0:`I2CSA_REG_WORDS-1];

  always @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Contents are not cleared by reset; only the read port is
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_data_q <= `I2CSA_BYTE_RST;
    end else begin
      rd_data_q <= mem[rd_addr];
    end
  end

endmodule // i2csa_regfile
`default_nettype wire

// [verification/i2csa_master.sv]
// Bus master model that drives the clock and data lines of the slave
`timescale 1ns/1ns
`default_nettype none
module i2csa_master (
  input  wire logic clk_sys,
  input  wire logic sda_w,
  output var  logic scl,
  output var  logic sda_m
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic t(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic start();
    t(1);
    sda_m = 1'b1;
    t(5);
    scl = 1'b1;
    t(8);
    sda_m = 1'b0;
    t(8);
    scl = 1'b0;
    t(4);
  endtask
  task automatic stop();
    t(1);
    sda_m = 1'b0;
    t(5);
    scl = 1'b1;
    t(8);
    sda_m = 1'b1;
    t(8);
  endtask
  // steady while high
  // 160 ns bit: six cycles low so the slave answers before the clock rises
  task automatic bitx(input logic b, output logic r);
    t(1);
    sda_m = b;
    t(5);
    scl = 1'b1;
    t(1);
    r = sda_w;
    t(1);
    scl = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(d[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(1'b1, d[i]);
    bitx(~ack, r);
  endtask
endmodule // i2csa_master
`default_nettype wire

// [verification/i2csa_slave_asserts.sv]
// Concurrent checks on the ports of the two-wire slave
`timescale 1ns/1ns
`default_nettype none
module i2csa_slave_asserts (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       addr_strap_high,
  input wire logic       addr_strap_low,
  input wire logic       rx_ready,
  input wire logic       wr_valid_q,
  input wire logic [3:0] wr_addr_q,
  input wire logic [7:0] wr_data_q,
  input wire logic       bus_busy_q,
  input wire logic       addressed_q,
  input wire logic       dir_read_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  drive_low_a: assert property (sda_out == 1'b0) else $error("data drive value not low");
  // released when free; one cycle slack for the stop edge
  oe_idle_a: assert property (!bus_busy_q && !$past(bus_busy_q) |-> !sda_oe) else $error("data driven on free bus");
  oe_rise_low_a: assert property ($rose(sda_oe) |-> !scl_in) else $error("data pulled while clock high");
  wr_pulse_a: assert property (wr_valid_q |=> !wr_valid_q) else $error("write pulse too long");
  wr_role_a: assert property (wr_valid_q |-> addressed_q && !dir_read_q && bus_busy_q) else $error("write outside role");
  wr_ack_a: assert property (wr_valid_q |-> sda_oe) else $error("write without ack");
  wr_ready_a: assert property (wr_valid_q |-> $past(rx_ready)) else $error("write while not ready");
  addr_free_a: assert property (!bus_busy_q && !$past(bus_busy_q) |-> !addressed_q) else $error("match kept after stop");
  busy_new_a: assert property ($rose(bus_busy_q) |-> !addressed_q) else $error("match held over start");
  cover property (wr_valid_q);
  cover property (addressed_q && dir_read_q);
  cover property ($fell(bus_busy_q));
endmodule // i2csa_slave_asserts
bind i2csa_slave i2csa_slave_asserts u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_high(addr_strap_high), .addr_strap_low(addr_strap_low),
  .rx_ready(rx_ready), .wr_valid_q(wr_valid_q), .wr_addr_q(wr_addr_q), .wr_data_q(wr_data_q),
  .bus_busy_q(bus_busy_q), .addressed_q(addressed_q), .dir_read_q(dir_read_q));
`default_nettype wire

// [verification/i2csa_slave_test.sv]
// Self-checking bench for the strap-addressed two-wire slave
`timescale 1ns/1ns
`default_nettype none
`include "i2csa_map.vh"
module i2csa_slave_test;
  logic       clk_sys = 1'b0;
  logic       rst_n = 1'b0;
  logic       rx_ready = 1'b1;
  logic [1:0] hi_c = 2'h0;
  logic [1:0] lo_c = 2'h0;
  logic       a;
  logic [7:0] d;
  logic [7:0] wd;
  logic [3:0] wr_a [$];
  logic [7:0] wr_d [$];
  int         error_cnt = 0;
  int         n_compared = 0;
  int         cyc = 0;
  wire logic  scl, sda_m, sda_w, sda_out, sda_oe, s_hi, s_lo;
  wire logic  wr_valid_q, bus_busy_q, addressed_q, dir_read_q;
  wire logic [3:0] wr_addr_q;
  wire logic [7:0] wr_data_q;
  function automatic logic strap(input logic [1:0] c, input logic l, input logic w);
    return c == 2'h0 ? 1'b1 : c == 2'h1 ? 1'b0 : c == 2'h2 ? l : w;
  endfunction
  function automatic logic [7:0] own();
    return 8'h90 + {3'h0, hi_c, lo_c, 1'b0};
  endfunction
  // Pull-up wire: released line reads high
  assign sda_w = sda_m & (sda_oe ? sda_out : 1'b1);
  assign s_hi = strap(hi_c, scl, sda_w);
  assign s_lo = strap(lo_c, scl, sda_w);
  always #10 clk_sys = ~clk_sys;
  i2csa_master m (.clk_sys(clk_sys), .sda_w(sda_w), .scl(scl), .sda_m(sda_m));
  i2csa_slave dut (.clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_strap_high(s_hi), .addr_strap_low(s_lo), .rx_ready(rx_ready),
    .wr_valid_q(wr_valid_q), .wr_addr_q(wr_addr_q), .wr_data_q(wr_data_q), .bus_busy_q(bus_busy_q),
    .addressed_q(addressed_q), .dir_read_q(dir_read_q));
  task automatic close_out();
    if (error_cnt == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Ceiling well above the roughly 5000 cycles the scenarios need
  always @(posedge clk_sys) begin
    cyc++;
    if (wr_valid_q === 1'b1) begin
      wr_a.push_back(wr_addr_q);
      wr_d.push_back(wr_data_q);
    end
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic s_idle();
    chk(sda_oe, 1'b0);
    chk(bus_busy_q, 1'b0);
    chk(addressed_q, 1'b0);
  endtask
  task automatic s_table();
    for (int i = 0; i < 16; i++) begin
      {hi_c, lo_c} = i[3:0];
      m.start();
      m.wbyte(own(), a);
      chk(a, 1'b1);
      chk(addressed_q, 1'b1);
      chk(bus_busy_q, 1'b1);
      m.start();
      m.wbyte(own() ^ 8'h02, a);
      chk(a, 1'b0);
      chk(addressed_q, 1'b0);
      m.stop();
      chk(bus_busy_q, 1'b0);
    end
  endtask
  task automatic s_write();
    {hi_c, lo_c} = 4'hb;
    // Last byte has bit 7 clear so a slave that keeps sending after nack shows
    wd = 8'hc0;
    m.start();
    m.wbyte(own(), a);
    chk(a, 1'b1);
    m.wbyte(8'ha9, a);
    chk(a, 1'b1);
    for (int i = 0; i < 3; i++) begin
      wd = wd + 8'h31;
      m.wbyte(wd, a);
      chk(a, 1'b1);
      chk(wr_d[$], wd);
      chk(wr_a[$], 4'h5);
    end
    m.stop();
    chk(addressed_q, 1'b0);
  endtask
  // bytes without a start are ignored
  task automatic s_nostart();
    m.wbyte(own(), a);
    chk(a, 1'b0);
    chk(addressed_q, 1'b0);
    m.stop();
  endtask
  task automatic s_read();
    m.start();
    m.wbyte(own(), a);
    m.wbyte(8'h28, a);
    m.start();
    m.wbyte(own() | 8'h01, a);
    chk(a, 1'b1);
    chk(dir_read_q, 1'b1);
    m.rbyte(1'b1, d);
    chk(d, wd);
    m.rbyte(1'b0, d);
    chk(d, wd);
    m.t(8);
    chk(sda_oe, 1'b0);
    m.stop();
  endtask
  task automatic s_refuse();
    int n0;
    n0 = wr_a.size();
    m.start();
    m.wbyte(own(), a);
    m.wbyte(8'h2a, a);
    chk(a, 1'b0);
    m.start();
    m.wbyte(own(), a);
    m.wbyte(8'h28, a);
    rx_ready = 1'b0;
    m.wbyte(8'hc3, a);
    chk(a, 1'b0);
    m.wbyte(8'hc3, a);
    chk(a, 1'b0);
    m.stop();
    rx_ready = 1'b1;
    chk(8'(wr_a.size() - n0), 8'h00);
  endtask
  initial begin
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (8) @(negedge clk_sys);
    s_idle();
    s_table();
    s_write();
    s_nostart();
    s_read();
    s_refuse();
    close_out();
  end
endmodule // i2csa_slave_test
`default_nettype wire
